/* hdl/twm_cfg.svh */
// Constants for the timer waveform output block.
// Assumes inclusion by bare name from the hdl folder.
`ifndef TWM_CFG_SVH
`define TWM_CFG_SVH
`define TWM_CNT_W 8
`define TWM_BOTTOM 8'h00
`define TWM_MAX 8'hff
`define TWM_ONE 8'h01
`define TWM_PSC_W 10
`define TWM_CS_W 3
`define TWM_CS_STOP 3'h0
`define TWM_CS_DIV1 3'h1
`define TWM_CS_DIV8 3'h2
`define TWM_CS_DIV32 3'h3
`define TWM_CS_DIV64 3'h4
`define TWM_CS_DIV128 3'h5
`define TWM_CS_DIV256 3'h6
`define TWM_CS_DIV1024 3'h7
`define TWM_MSK_DIV1 10'h000
`define TWM_MSK_DIV8 10'h007
`define TWM_MSK_DIV32 10'h01f
`define TWM_MSK_DIV64 10'h03f
`define TWM_MSK_DIV128 10'h07f
`define TWM_MSK_DIV256 10'h0ff
`define TWM_MSK_DIV1024 10'h3ff
`endif

/* hdl/twm_pkg.sv */
// Types for the timer waveform output block.
// Assumes nothing beyond the compile order.
package twm_pkg;
  typedef enum logic [1:0] {
    TWM_WGM_NORMAL = 2'h0,
    TWM_WGM_PCPWM = 2'h1,
    TWM_WGM_CTC = 2'h2,
    TWM_WGM_FAST = 2'h3
  } twm_wgm_t;
  typedef enum logic [1:0] {
    TWM_COM_OFF = 2'h0,
    TWM_COM_TOGGLE = 2'h1,
    TWM_COM_CLEAR = 2'h2,
    TWM_COM_SET = 2'h3
  } twm_com_t;
endpackage

/* hdl/twm_prescaler.sv */
// Prescaler producing the one-cycle timer clock enable.
// Assumes clock select comes from logic on sys_clk_in.
`timescale 1ns/1ps
`include "twm_cfg.svh"
module twm_prescaler
  import twm_pkg::*;
#(
  parameter int PSC_W = `TWM_PSC_W
) (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  // Control
  input wire logic [`TWM_CS_W-1:0] clock_select_in,
  // Timer clock enable
  output logic tick_out
);
  logic [PSC_W-1:0] div_r;
  logic [PSC_W-1:0] mask;

  always_comb begin
    case (clock_select_in)
      `TWM_CS_DIV1: mask = PSC_W'(`TWM_MSK_DIV1);
      `TWM_CS_DIV8: mask = PSC_W'(`TWM_MSK_DIV8);
      `TWM_CS_DIV32: mask = PSC_W'(`TWM_MSK_DIV32);
      `TWM_CS_DIV64: mask = PSC_W'(`TWM_MSK_DIV64);
      `TWM_CS_DIV128: mask = PSC_W'(`TWM_MSK_DIV128);
      `TWM_CS_DIV256: mask = PSC_W'(`TWM_MSK_DIV256);
      `TWM_CS_DIV1024: mask = PSC_W'(`TWM_MSK_DIV1024);
      default: mask = '0;
    endcase
  end

  // Free-running divider shared by all ratios
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      div_r <= '0;
    end else begin
      div_r <= div_r + PSC_W'(1);
    end
  end

  // Stopped when no source selected
  assign tick_out = (clock_select_in != `TWM_CS_STOP) && ((div_r & mask) == mask);
endmodule

/* hdl/twm_top.sv */
// Counter, comparator and compare output logic of an 8-bit timer.
// Assumes all control inputs come from registers on sys_clk_in.
//
// Overview of operation
// - Nonzero compare output mode routes compare output state to the pin.
// - Pin direction follows only its direction bit.
// - Pin override works the same in every waveform mode.
// - Compare output state is a register, settable before pin enable.
// - Mode zero leaves compare output state untouched on match.
// - New compare output mode acts from the next match on.
// - Force strobe applies the match action at once in non-PWM modes.
// - Mode 0 counts up forever, wrapping 0xFF to 0x00.
// - Normal mode sets overflow flag as counter becomes zero; never clears.
// - Mode 2 clears counter on match; compare value is top.
// - Clear-on-compare sets compare flag each time top is reached.
// - Clear-on-compare compare value unbuffered; missed match runs to wrap.
// - Clear-on-compare mode 1 toggles output on each match.
// - Toggle frequency is clock over 2 times prescale times top+1.
// - Clear-on-compare sets overflow flag on wrapping MAX to 0x00 without a match at MAX.
// - Prescale factor selectable 1, 8, 32, 64, 128, 256, 1024.
// - Mode 3 counts bottom to MAX, clears on next timer cycle.
// - Fast PWM mode 2 clears on match, sets at bottom; 3 inverted.
// - Fast PWM sets overflow flag each time MAX is reached.
// - Fast PWM period is prescale times 256 clocks.
// - Compare at bottom gives spikes; at MAX a constant level.
// - Fast PWM mode 1 toggles on match; compare stays double buffered.
// - Comparator match sets compare flag on next timer cycle.
// - Compare value buffered in PWM, updated at top; direct otherwise.
`timescale 1ns/1ps
`include "twm_cfg.svh"
module twm_top
  import twm_pkg::*;
#(
  parameter int CNT_W = `TWM_CNT_W
) (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  // Configuration
  input wire logic [1:0] waveform_mode_select_in,
  input wire logic [1:0] compare_output_mode_in,
  input wire logic [`TWM_CS_W-1:0] clock_select_in,
  // Software writes and strobes
  input wire logic compare_value_wr_in,
  input wire logic [CNT_W-1:0] compare_value_in,
  input wire logic counter_wr_in,
  input wire logic [CNT_W-1:0] counter_wr_data_in,
  input wire logic force_compare_strobe_in,
  input wire logic overflow_flag_clr_in,
  input wire logic compare_flag_clr_in,
  // General port bits
  input wire logic port_data_in,
  input wire logic compare_pin_direction_bit_in,
  // Status
  output logic [CNT_W-1:0] counter_value_out,
  output logic [CNT_W-1:0] compare_value_out,
  output logic overflow_flag_out,
  output logic compare_flag_out,
  output logic compare_output_state_out,
  // Compare pin
  output logic pin_out,
  output logic pin_oe_out
);
  twm_wgm_t wgm;
  twm_com_t com;
  logic tick;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic [CNT_W-1:0] ocr_r;
  logic [CNT_W-1:0] ocr_buf_r;
  logic block_r;
  logic ovf_r;
  logic ocf_r;
  logic oc_r;
  logic oc_nxt;
  logic pin_r;
  logic pin_oe_r;
  logic is_pwm;
  logic at_max;
  logic match;
  logic force_act;

  assign wgm = twm_wgm_t'(waveform_mode_select_in);
  assign com = twm_com_t'(compare_output_mode_in);
  assign is_pwm = (wgm == TWM_WGM_FAST) || (wgm == TWM_WGM_PCPWM);
  assign at_max = (cnt_r == CNT_W'(`TWM_MAX));

  twm_prescaler u_psc (
    .sys_clk_in(sys_clk_in),
    .nrst_in(nrst_in),
    .clock_select_in(clock_select_in),
    .tick_out(tick)
  );

  // Comparator, held off for one timer cycle after a counter write
  assign match = (cnt_r == ocr_r) && !block_r;
  assign force_act = force_compare_strobe_in && !is_pwm;

  // Counter next value; software write has priority
  always_comb begin
    cnt_nxt = cnt_r;
    if (counter_wr_in) begin
      cnt_nxt = counter_wr_data_in;
    end else if (tick) begin
      if ((wgm == TWM_WGM_CTC) && match) begin
        cnt_nxt = CNT_W'(`TWM_BOTTOM);
      end else begin
        cnt_nxt = cnt_r + CNT_W'(`TWM_ONE);
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cnt_r <= CNT_W'(`TWM_BOTTOM);
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // Blocks the match of the next timer cycle after a counter write
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      block_r <= 1'b0;
    end else if (counter_wr_in) begin
      block_r <= 1'b1;
    end else if (tick) begin
      block_r <= 1'b0;
    end
  end

  // Compare value: direct outside PWM, loaded at top in PWM
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ocr_buf_r <= CNT_W'(`TWM_BOTTOM);
    end else if (compare_value_wr_in) begin
      ocr_buf_r <= compare_value_in;
    end
  end

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ocr_r <= CNT_W'(`TWM_BOTTOM);
    end else if (!is_pwm) begin
      if (compare_value_wr_in) begin
        ocr_r <= compare_value_in;
      end else begin
        ocr_r <= ocr_buf_r;
      end
    end else if (tick && at_max) begin
      ocr_r <= ocr_buf_r;
    end
  end

  // Overflow flag: set on MAX to 0x00 in every mode except a clear-on-compare match at MAX; set beats clear
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ovf_r <= 1'b0;
    end else if (tick && !counter_wr_in && at_max && !((wgm == TWM_WGM_CTC) && match)) begin
      ovf_r <= 1'b1;
    end else if (overflow_flag_clr_in) begin
      ovf_r <= 1'b0;
    end
  end

  // Compare flag: set on the timer cycle after the match; set beats clear
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ocf_r <= 1'b0;
    end else if (tick && match) begin
      ocf_r <= 1'b1;
    end else if (compare_flag_clr_in) begin
      ocf_r <= 1'b0;
    end
  end

  // Waveform generator action on match, bottom or force
  always_comb begin
    oc_nxt = oc_r;
    if (wgm == TWM_WGM_FAST) begin
      if (tick && match) begin
        case (com)
          TWM_COM_TOGGLE: oc_nxt = !oc_r;
          TWM_COM_CLEAR: oc_nxt = 1'b0;
          TWM_COM_SET: oc_nxt = 1'b1;
          default: oc_nxt = oc_r;
        endcase
      end
      if (tick && at_max) begin
        // Bottom action wins, so compare at MAX gives a constant level
        case (com)
          TWM_COM_CLEAR: oc_nxt = 1'b1;
          TWM_COM_SET: oc_nxt = 1'b0;
          default: oc_nxt = oc_nxt;
        endcase
      end
    end else if (!is_pwm && ((tick && match) || force_act)) begin
      case (com)
        TWM_COM_TOGGLE: oc_nxt = !oc_r;
        TWM_COM_CLEAR: oc_nxt = 1'b0;
        TWM_COM_SET: oc_nxt = 1'b1;
        default: oc_nxt = oc_r;
      endcase
    end
  end

  // Internal compare output state, kept across mode changes
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      oc_r <= 1'b0;
    end else begin
      oc_r <= oc_nxt;
    end
  end

  // Pin source and direction, mode independent
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pin_r <= 1'b0;
      pin_oe_r <= 1'b0;
    end else begin
      pin_r <= (com != TWM_COM_OFF) ? oc_nxt : port_data_in;
      pin_oe_r <= compare_pin_direction_bit_in;
    end
  end

  assign counter_value_out = cnt_r;
  assign compare_value_out = ocr_r;
  assign overflow_flag_out = ovf_r;
  assign compare_flag_out = ocf_r;
  assign compare_output_state_out = oc_r;
  assign pin_out = pin_r;
  assign pin_oe_out = pin_oe_r;

  // Checks
  property p_wrap;
    @(posedge sys_clk_in) disable iff (!nrst_in)
      (tick && !counter_wr_in && at_max && wgm != TWM_WGM_CTC) |=> (cnt_r == CNT_W'(`TWM_BOTTOM));
  endproperty
  AST_WRAP_TO_BOTTOM: assert property (p_wrap) else $error("Counter did not wrap to bottom");
  AST_OVF_SET: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    (tick && !counter_wr_in && at_max && wgm == TWM_WGM_NORMAL) |=> ovf_r && cnt_r == CNT_W'(`TWM_BOTTOM))
    else $error("Overflow flag not set at wrap");
  AST_OVF_HELD: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    (ovf_r && !overflow_flag_clr_in) |=> ovf_r)
    else $error("Overflow flag cleared by hardware");
  AST_CTC_CLEAR: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    (tick && !counter_wr_in && match && wgm == TWM_WGM_CTC) |=> cnt_r == CNT_W'(`TWM_BOTTOM) && ocf_r)
    else $error("Clear-on-compare did not clear counter");
  AST_CTC_TOGGLE: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    (tick && match && wgm == TWM_WGM_CTC && com == TWM_COM_TOGGLE) |=> oc_r != $past(oc_r))
    else $error("Toggle missing on match");
  AST_COM_OFF: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    (com == TWM_COM_OFF) |=> $stable(oc_r))
    else $error("Output state changed with mode off");
  AST_FORCE: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    (force_compare_strobe_in && !is_pwm && com == TWM_COM_SET) |=> oc_r && pin_r)
    else $error("Force strobe did not set output");
  AST_FORCE_NO_FLAG: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    (force_compare_strobe_in && !(tick && match) && !ocf_r) |=> !ocf_r)
    else $error("Force strobe set compare flag");
  AST_PIN_SRC: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    (com != TWM_COM_OFF) ##1 (com != TWM_COM_OFF) |-> pin_r == oc_r)
    else $error("Pin not driven by output state");
  AST_PIN_PORT: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    (com == TWM_COM_OFF) |=> pin_r == $past(port_data_in))
    else $error("Pin not driven by port value");
  AST_PIN_DIR: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    1'b1 |=> pin_oe_r == $past(compare_pin_direction_bit_in))
    else $error("Pin direction not from direction bit");
  AST_FLAG_DELAY: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    (!ocf_r && !(tick && match)) |=> !ocf_r)
    else $error("Compare flag set without match");
  AST_FAST_BOTTOM: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    (tick && at_max && wgm == TWM_WGM_FAST && com == TWM_COM_CLEAR) |=> oc_r)
    else $error("Fast PWM bottom did not set output");
  AST_FAST_MATCH: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    (tick && match && !at_max && wgm == TWM_WGM_FAST && com == TWM_COM_SET) |=> oc_r)
    else $error("Fast PWM inverted match did not set output");
  AST_BUFFERED: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    (wgm == TWM_WGM_FAST && !(tick && at_max)) |=> $stable(ocr_r))
    else $error("Buffered compare value changed off top");
  AST_BLOCK: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    counter_wr_in ##1 (tick && !counter_wr_in) |=> !$rose(ocf_r))
    else $error("Match not blocked after counter write");
  AST_CNT_STEP: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    (tick && !counter_wr_in && !at_max && wgm == TWM_WGM_NORMAL) |=> cnt_r == $past(cnt_r) + CNT_W'(`TWM_ONE))
    else $error("Counter did not step up");
  AST_NORMAL_NO_CLR: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    (tick && !counter_wr_in && match && !at_max && wgm == TWM_WGM_NORMAL) |=> cnt_r != CNT_W'(`TWM_BOTTOM))
    else $error("Normal mode cleared counter on match");
  AST_CNT_HOLD: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    (!tick && !counter_wr_in) |=> $stable(cnt_r))
    else $error("Counter moved without timer tick");
  AST_STOPPED: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    (clock_select_in == `TWM_CS_STOP) |-> !tick)
    else $error("Timer tick while stopped");
  AST_DIV1: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    (clock_select_in == `TWM_CS_DIV1) |-> tick)
    else $error("Timer tick missing at divide by one");
  AST_CTC_OVF: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    (tick && !counter_wr_in && at_max && !match && wgm == TWM_WGM_CTC) |=> ovf_r && cnt_r == CNT_W'(`TWM_BOTTOM))
    else $error("Clear-on-compare wrap did not set overflow flag");
  AST_FAST_OVF: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    (tick && !counter_wr_in && at_max && wgm == TWM_WGM_FAST) |=> ovf_r)
    else $error("Fast PWM overflow flag not set at max");
  AST_FAST_CLEAR: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    (tick && match && !at_max && wgm == TWM_WGM_FAST && com == TWM_COM_CLEAR) |=> !oc_r)
    else $error("Fast PWM match did not clear output");
  AST_FAST_INV_BOTTOM: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    (tick && at_max && wgm == TWM_WGM_FAST && com == TWM_COM_SET) |=> !oc_r)
    else $error("Fast PWM inverted bottom did not clear output");
  AST_FAST_TOGGLE: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    (tick && match && wgm == TWM_WGM_FAST && com == TWM_COM_TOGGLE) |=> oc_r != $past(oc_r))
    else $error("Fast PWM toggle missing on match");
  AST_DIRECT_CMP: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    (!is_pwm && compare_value_wr_in) |=> ocr_r == $past(compare_value_in))
    else $error("Compare value not written directly");
  AST_PWM_LOAD: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    (is_pwm && tick && at_max) |=> ocr_r == $past(ocr_buf_r))
    else $error("Compare buffer not loaded at top");
  AST_FORCE_PWM: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    (force_compare_strobe_in && wgm == TWM_WGM_PCPWM) |=> $stable(oc_r))
    else $error("Force strobe acted in PWM mode");
  AST_FORCE_NO_CLR: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    (force_compare_strobe_in && !tick && !counter_wr_in) |=> $stable(cnt_r))
    else $error("Force strobe moved the counter");
  AST_COM_CLEAR: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    (!is_pwm && tick && match && com == TWM_COM_CLEAR) |=> !oc_r)
    else $error("Clear action missing on match");
  AST_COM_SET: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    (!is_pwm && tick && match && com == TWM_COM_SET) |=> oc_r)
    else $error("Set action missing on match");
  AST_OC_HELD: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    (!tick && !force_compare_strobe_in) |=> $stable(oc_r))
    else $error("Output state changed without event");
  AST_FLAG_CLR: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    (ocf_r && compare_flag_clr_in && !(tick && match)) |=> !ocf_r)
    else $error("Compare flag not cleared");

  COV_CTC_TOGGLE: cover property (@(posedge sys_clk_in) disable iff (!nrst_in)
    tick && match && wgm == TWM_WGM_CTC && com == TWM_COM_TOGGLE);
  COV_FAST_PWM: cover property (@(posedge sys_clk_in) disable iff (!nrst_in)
    tick && at_max && wgm == TWM_WGM_FAST && com == TWM_COM_CLEAR);
  COV_FORCE: cover property (@(posedge sys_clk_in) disable iff (!nrst_in)
    force_compare_strobe_in && !is_pwm && com != TWM_COM_OFF);
  COV_OVF: cover property (@(posedge sys_clk_in) disable iff (!nrst_in) $rose(ovf_r));
  COV_CTC_WRAP: cover property (@(posedge sys_clk_in) disable iff (!nrst_in)
    tick && at_max && !match && wgm == TWM_WGM_CTC);
endmodule

/* tb/timer_waveform_output_modes_bench.sv */
// Self-checking bench for the timer waveform output block.
// Assumes twm_pkg and twm_cfg.svh are compiled first.
`timescale 1ns/1ps
module timer_waveform_output_modes_bench;
  import twm_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [1:0] wms = 2'h0;
  logic [1:0] com = 2'h0;
  logic [2:0] cs = 3'h0;
  logic cw = 1'b0;
  logic [7:0] cv = 8'h00;
  logic nw = 1'b0;
  logic [7:0] nd = 8'h00;
  logic fs = 1'b0;
  logic oc = 1'b0;
  logic cc = 1'b0;
  logic pd = 1'b0;
  logic dd = 1'b0;
  logic [7:0] cnt, cmp;
  logic ovf, cf, st, pin, oe, lvl;
  int n_fail = 0;
  int checks = 0;
  int cycles = 0;
  int ni;
  logic [15:0] m;
  int nf[8] = '{0, 1, 8, 32, 64, 128, 256, 1024};
  logic [18:0] pw[4] = '{{2'h2, 8'h00, 9'h001}, {2'h2, 8'hff, 9'h100}, {2'h2, 8'h40, 9'h041},
    {2'h3, 8'h40, 9'h0bf}};

  twm_top dut (.sys_clk_in(clk), .nrst_in(nrst), .waveform_mode_select_in(wms),
    .compare_output_mode_in(com), .clock_select_in(cs), .compare_value_wr_in(cw),
    .compare_value_in(cv), .counter_wr_in(nw), .counter_wr_data_in(nd),
    .force_compare_strobe_in(fs), .overflow_flag_clr_in(oc), .compare_flag_clr_in(cc),
    .port_data_in(pd), .compare_pin_direction_bit_in(dd), .counter_value_out(cnt),
    .compare_value_out(cmp), .overflow_flag_out(ovf), .compare_flag_out(cf),
    .compare_output_state_out(st), .pin_out(pin), .pin_oe_out(oe));
  twm_load load (.pin_in(pin), .pin_oe_in(oe), .level_out(lvl));

  always #25 clk = ~clk;

  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      n_fail++;
      results();
    end
  end

  task automatic results();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic wr_cnt(input logic [7:0] v);
    nd = v;
    nw = 1'b1;
    cyc(1);
    nw = 1'b0;
  endtask

  task automatic wr_cmp(input logic [7:0] v);
    cv = v;
    cw = 1'b1;
    cyc(1);
    cw = 1'b0;
  endtask

  task automatic clr_flags();
    oc = 1'b1;
    cc = 1'b1;
    cyc(1);
    oc = 1'b0;
    cc = 1'b0;
  endtask

  task automatic wait_cnt(input logic [7:0] v, input int lim);
    int i;
    i = 0;
    while (cnt !== v && i < lim) begin
      cyc(1);
      i++;
    end
    check(cnt, v, "counter not reached");
  endtask

  // Cycles between two successive changes of the state
  task automatic gap(input int lim, output logic [15:0] g);
    logic s;
    int i;
    i = 0;
    s = st;
    while (st === s && i < lim) begin
      cyc(1);
      i++;
    end
    s = st;
    g = 0;
    while (st === s && g < lim) begin
      cyc(1);
      g++;
    end
  endtask

  task automatic high_cnt(input int w, output logic [15:0] h);
    h = 0;
    repeat (w) begin
      cyc(1);
      h = h + lvl;
    end
  endtask

  initial begin
    cyc(10);
    nrst = 1'b1;
    cyc(1);
    check({cnt, ovf, cf, st}, 11'h000, "reset outputs");
    check({cmp, pin, oe}, 10'h000, "reset outputs");
    $display("reset test done");
    // Force in normal mode, pin still an input
    com = 2'h3;
    fs = 1'b1;
    cyc(1);
    fs = 1'b0;
    cyc(2);
    check(st, 1'b1, "forced set");
    check(cf, 1'b0, "flag from force");
    check({oe, lvl}, 2'b00, "pin driven while input");
    dd = 1'b1;
    cyc(2);
    check(lvl, 1'b1, "state not on pin");
    com = 2'h0;
    pd = 1'b0;
    cyc(2);
    check(lvl, 1'b0, "port value not on pin");
    pd = 1'b1;
    fs = 1'b1;
    cyc(1);
    fs = 1'b0;
    cyc(2);
    check(lvl, 1'b1, "port value not on pin");
    check(st, 1'b1, "state changed with mode zero");
    $display("force and pin test done");
    // Normal wrap
    cs = 3'h1;
    wr_cnt(8'hfe);
    wait_cnt(8'h00, 10);
    check(ovf, 1'b1, "overflow on wrap");
    cyc(3);
    check(ovf, 1'b1, "overflow cleared by itself");
    $display("normal test done");
    // Clear on compare: top and missed match
    cs = 3'h0;
    wms = 2'h2;
    wr_cmp(8'h05);
    wr_cnt(8'h00);
    clr_flags();
    cs = 3'h1;
    wait_cnt(8'h05, 20);
    cyc(1);
    check(cnt, 8'h00, "no clear at top");
    cyc(1);
    check(cf, 1'b1, "compare flag at top");
    check(ovf, 1'b0, "overflow without wrap");
    wait_cnt(8'h03, 20);
    wr_cmp(8'h01);
    clr_flags();
    wait_cnt(8'h00, 300);
    check(ovf, 1'b1, "overflow after missed match");
    check(cf, 1'b0, "match not missed");
    $display("clear on compare test done");
    // Toggle period for every prescale
    com = 2'h1;
    for (ni = 1; ni < 8; ni++) begin
      cs = 3'h0;
      wr_cmp(8'h01);
      wr_cnt(8'h00);
      cs = ni[2:0];
      gap(5000, m);
      check(m, 16'(2 * nf[ni]), "toggle period");
    end
    // New compare output mode acts at the next match
    cs = 3'h1;
    com = 2'h2;
    cyc(8);
    check(st, 1'b0, "clear on match");
    com = 2'h3;
    cyc(8);
    check({st, lvl}, 2'b11, "set on match");
    // Force ignored in a PWM mode
    wms = 2'h1;
    com = 2'h2;
    fs = 1'b1;
    cyc(1);
    fs = 1'b0;
    cyc(2);
    check(st, 1'b1, "force acted in pwm");
    $display("toggle period test done");
    // Fast PWM duty and extremes on the pin
    wms = 2'h3;
    cs = 3'h1;
    for (ni = 0; ni < 4; ni++) begin
      com = pw[ni][18:17];
      wr_cmp(pw[ni][16:9]);
      cyc(600);
      clr_flags();
      high_cnt(256, m);
      check(m, {2'b00, pw[ni][8:0]}, "high cycles per period");
      check(ovf, 1'b1, "overflow at max");
    end
    wait_cnt(8'h10, 300);
    wr_cmp(8'h80);
    cyc(2);
    check(cmp, 8'h40, "compare not buffered");
    wait_cnt(8'h00, 300);
    cyc(2);
    check(cmp, 8'h80, "buffer not loaded");
    com = 2'h1;
    wr_cmp(8'h20);
    wait_cnt(8'h00, 300);
    gap(600, m);
    check(m, 11'h100, "fast toggle period");
    $display("fast pwm test done");
    results();
  end
endmodule

/* tb/twm_load.sv */
// External load on the compare pin, with a pull-down.
// Assumes the pin and its enable come straight from the timer.
`timescale 1ns/1ps
module twm_load (
  // Pin from the timer
  input wire logic pin_in,
  input wire logic pin_oe_in,
  // Level seen by the load
  output logic level_out
);
  // Undriven pin falls to the pull-down
  assign level_out = pin_oe_in ? pin_in : 1'b0;
endmodule
